// >>> verification/spm_master_chk.sv
`timescale 1ns/1ns
`default_nettype none
module spm_master_chk
  import spm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Interrupt and serial clock
  input wire logic irq,
  input wire logic sck_out,
  // RAM channels
  input wire logic mem_rd_req,
  input wire logic [31:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic mem_wr_req,
  input wire logic [31:0] mem_wr_addr,
  input wire logic [7:0] mem_wr_data,
  input wire logic mem_wr_ack
);
  // ****************
  // Tracked state
  // ****************
  logic en_on, cpol;
  logic [3:0] mask;
  logic [9:0] half, hi_n;
  logic [12:0] tx_max, rx_max, rd_n, wr_n;
  int since;
  wire logic start = reg_wr && reg_addr == OFF_TASK_START && reg_wdata[0];
  function automatic logic [9:0] half_of(input logic [31:0] r);
    half_of = 10'h0FA;
    for (int b = 0; b < 7; b++) begin
      if (r == 32'h02000000 << b) begin
        half_of = 10'h1F4 >> b;
      end
    end
  endfunction : half_of
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      en_on <= 1'b0;
      cpol <= 1'b0;
      mask <= 4'h0;
      half <= 10'h0FA;
      tx_max <= 13'h0;
      rx_max <= 13'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        OFF_ENABLE: en_on <= reg_wdata[3:0] == ENABLE_ON;
        OFF_FORMAT: cpol <= reg_wdata[FMT_CPOL_BIT];
        OFF_INT_MASK: mask <= reg_wdata[3:0];
        OFF_BIT_RATE: half <= half_of(reg_wdata);
        OFF_TX_MAX: tx_max <= reg_wdata[12:0];
        OFF_RX_MAX: rx_max <= reg_wdata[12:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      since <= 0;
      rd_n <= 13'h0;
      wr_n <= 13'h0;
      hi_n <= 10'h0;
    end else begin
      since <= start ? 0 : (since < 1000 ? since + 1 : since);
      rd_n <= start ? 13'h0 : rd_n + 13'(mem_rd_req && mem_rd_ack);
      wr_n <= start ? 13'h0 : wr_n + 13'(mem_wr_req && mem_wr_ack);
      hi_n <= sck_out ? hi_n + 10'h1 : 10'h0;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // ****************
  // Assertions
  // ****************
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("stray rdata");
  property p_start_lat;
    $rose(mem_rd_req) |-> since >= START_LAT_CYC - 1;
  endproperty
  a_start_lat: assert property (p_start_lat) else $error("early fetch");
  property p_rd_hold;
    mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("fetch dropped");
  property p_wr_hold;
    mem_wr_req && !mem_wr_ack |=> mem_wr_req && $stable(mem_wr_data);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("store dropped");
  property p_rd_max;
    mem_rd_req |-> rd_n < tx_max;
  endproperty
  a_rd_max: assert property (p_rd_max) else $error("too many fetches");
  property p_wr_max;
    mem_wr_req |-> wr_n < rx_max;
  endproperty
  a_wr_max: assert property (p_wr_max) else $error("too many stores");
  property p_disabled;
    !en_on && !$past(en_on) |-> !mem_rd_req && !mem_wr_req;
  endproperty
  a_disabled: assert property (p_disabled) else $error("runs disabled");
  property p_sck_idle;
    !en_on && !$past(en_on) && cpol == $past(cpol) && cpol == $past(cpol, 2)
      |-> sck_out == cpol;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck idle");
  property p_sck_high;
    $fell(sck_out) && !cpol |-> hi_n == half;
  endproperty
  a_sck_high: assert property (p_sck_high) else $error("sck high time");
  property p_irq_mask;
    mask == 4'h0 && $past(mask) == 4'h0 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq masked");
endmodule : spm_master_chk
bind spm_master spm_master_chk i_spm_master_chk (.ref_clk, .resetn,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .sck_out,
  .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_wr_req, .mem_wr_addr,
  .mem_wr_data, .mem_wr_ack);
`default_nettype wire

// >>> verification/spm_slave.sv
`timescale 1ns/1ns
`default_nettype none
module spm_slave #(
  parameter logic [7:0] SLV_BYTE = 8'hC6
) (
  // Serial side
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Mode in use and reset
  input wire logic cpol,
  input wire logic cpha,
  input wire logic resetn,
  // Last byte seen
  output logic [7:0] got
);
  logic [2:0] n = 3'h0;
  // Shift on one edge kind, sample on the other, as the mode says
  assign miso = cpha ? SLV_BYTE[3'h0 - n] : SLV_BYTE[3'h7 - n];
  always @(posedge sck or negedge sck) begin
    if (resetn) begin
      if ((sck != cpol) == cpha) begin
        n <= n + 3'h1;
      end else begin
        got <= {got[6:0], mosi};
      end
    end
  end
endmodule : spm_slave
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  mismatches++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, \
  g, e); end end
module tb
  import spm_pkg::*;
();
  // ****************
  // Signals
  // ****************
  logic ref_clk, resetn, reg_wr, reg_rd, irq, sck_out, mosi_out, miso;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, gpio_in, mem_rd_addr, mem_wr_addr;
  logic mem_rd_req, mem_rd_ack, mem_wr_req, mem_wr_ack;
  logic [7:0] mem_rd_data, mem_wr_data, got;
  logic [7:0] wq[$];
  logic slv_cpol, slv_cpha;
  int mismatches, comparisons, nrd, i, k;
  logic [31:0] codes[7] = '{rate_125k_code, RATE_250K_CODE,
    RATE_500K_CODE, RATE_1M_CODE, RATE_2M_CODE, RATE_4M_CODE, rate_8m_code};
  spm_master i_spm_master (.ref_clk, .resetn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq, .gpio_in, .sck_out, .mosi_out,
    .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .mem_wr_req,
    .mem_wr_addr, .mem_wr_data, .mem_wr_ack);
  spm_slave i_spm_slave (.sck(sck_out), .mosi(mosi_out), .miso,
    .cpol(slv_cpol), .cpha(slv_cpha), .resetn, .got);
  // Slave on pin 5, inverted copies elsewhere
  assign gpio_in = {{26{~miso}}, miso, {5{~miso}}};
  assign mem_rd_data = mem_rd_addr[7:0] ^ 8'h1D;
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ****************
  // RAM responder
  // ****************
  always @(posedge ref_clk) begin
    mem_rd_ack <= mem_rd_req && !mem_rd_ack;
    mem_wr_ack <= mem_wr_req && !mem_wr_ack;
    if (mem_wr_req && mem_wr_ack) begin
      wq.push_back(mem_wr_data);
    end
    if (mem_rd_req && mem_rd_ack) begin
      nrd++;
    end
  end
  // ****************
  // Tasks
  // ****************
  task automatic give_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    `CHK(d, e)
    @(posedge ref_clk);
  endtask : rc
  task automatic xfer(input logic [12:0] rx, input logic [12:0] tx);
    wq.delete();
    nrd = 0;
    wr(OFF_RX_MAX, 32'(rx));
    wr(OFF_TX_MAX, 32'(tx));
    wr(OFF_TASK_START, 32'h1);
    for (i = 0; i < 20000 && irq !== 1'b1; i++) begin
      @(posedge ref_clk);
    end
    if (irq !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
    `CHK(32'(wq.size()), 32'(rx))
    `CHK(32'(nrd), 32'(tx))
    rc(OFF_INT_STATUS, 32'hF);
    rc(OFF_INT_STATUS, 32'h0);
    `CHK(irq, 1'b0)
    rc(OFF_RX_AMOUNT, 32'(rx));
    rc(OFF_TX_AMOUNT, 32'(tx));
  endtask : xfer
  // ****************
  // Sequence
  // ****************
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    slv_cpol = 1'b0;
    slv_cpha = 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rc(OFF_IN_PIN_SEL, PIN_SEL_RESET);
    rc(OFF_BIT_RATE, BIT_RATE_RESET);
    rc(OFF_RX_MAX, 32'h0);
    rc(12'h5FC, 32'h0);
    wr(OFF_INT_MASK, 32'h4);
    wr(OFF_ENABLE, 32'h1);
    wr(OFF_TASK_START, 32'h1);
    repeat (200) @(posedge ref_clk);
    rc(OFF_INT_STATUS, 32'h0);
    wr(OFF_ENABLE, 32'h7);
    wr(OFF_RX_PTR, 32'h100);
    wr(OFF_TX_PTR, 32'h200);
    wr(OFF_FILL_CHAR, 32'h5A);
    wr(OFF_BIT_RATE, rate_8m_code);
    xfer(1, 1);
    `CHK(wq[0], 8'h00)
    wr(OFF_IN_PIN_SEL, 32'h5);
    rc(OFF_IN_PIN_SEL, 32'h5);
    xfer(3, 2);
    for (k = 0; k < 3; k++) begin
      `CHK(wq[k], 8'hC6)
    end
    `CHK(got, 8'h5A)
    wr(OFF_RX_AMOUNT, 32'h0);
    rc(OFF_RX_AMOUNT, 32'h3);
    xfer(1, 3);
    wr(OFF_FORMAT, 32'h1);
    xfer(1, 1);
    `CHK(wq[0], 8'h63)
    `CHK(got, 8'hB8)
    wr(OFF_FORMAT, 32'h0);
    for (k = 0; k < 7; k++) begin
      wr(OFF_BIT_RATE, codes[k]);
      xfer(1, 1);
      `CHK(wq[0], 8'hC6)
    end
    slv_cpol <= 1'b1;
    slv_cpha <= 1'b1;
    wr(OFF_FORMAT, 32'h6);
    xfer(1, 1);
    `CHK(wq[0], 8'hC6)
    `CHK(got, 8'h1D)
    wr(OFF_ENABLE, 32'h0);
    wr(OFF_FORMAT, 32'h4);
    repeat (4) @(posedge ref_clk);
    `CHK(sck_out, 1'b1)
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// >>> verilog/spm_master.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module spm_master
  import spm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Interrupt
  output logic irq,
  // Pins
  input wire logic [31:0] gpio_in,
  output logic sck_out,
  output logic mosi_out,
  // RAM read channel
  output logic mem_rd_req,
  output logic [31:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic [7:0] mem_rd_data,
  // RAM write channel
  output logic mem_wr_req,
  output logic [31:0] mem_wr_addr,
  output logic [7:0] mem_wr_data,
  input wire logic mem_wr_ack
);
  // ****************************************
  // Registers
  // ****************************************
  logic [3:0] enable;
  logic [31:0] pin_sel;
  logic [31:0] bit_rate;
  logic [31:0] rx_ptr;
  logic [31:0] tx_ptr;
  logic [CNT_W-1:0] rx_max;
  logic [CNT_W-1:0] tx_max;
  logic [CNT_W-1:0] rx_amount;
  logic [CNT_W-1:0] tx_amount;
  logic [1:0] rx_list;
  logic [1:0] tx_list;
  logic [2:0] fmt;
  logic [7:0] fill_char;
  logic [EV_W-1:0] int_status;
  logic [EV_W-1:0] int_mask;
  logic [EV_W-1:0] ev_set;
  spm_state_t state;
  spm_state_t next_state;
  logic [7:0] lat_cnt;
  logic [8:0] div_cnt;
  logic [8:0] half_cnt;
  logic [3:0] edge_cnt;
  logic [CNT_W-1:0] byte_cnt;
  logic [CNT_W-1:0] total;
  logic [CNT_W-1:0] rx_cnt;
  logic [CNT_W-1:0] tx_cnt;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic [31:0] gpio_sync;
  logic miso;
  logic running;
  logic start;
  logic tick;
  logic load;
  logic [7:0] load_byte;
  logic lsb_first;
  logic cpha;
  logic cpol;

  assign lsb_first = fmt[FMT_ORDER_BIT];
  assign cpha = fmt[FMT_CPHA_BIT];
  assign cpol = fmt[FMT_CPOL_BIT];
  assign running = (enable == ENABLE_ON);
  assign start = reg_wr && reg_addr == OFF_TASK_START && reg_wdata[0] &&
    running;
  assign total = (rx_max > tx_max) ? rx_max : tx_max;

  // ****************************************
  // Input pin routing
  // ****************************************
  spm_sync #(.W(32)) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .d(gpio_in),
    .q(gpio_sync)
  );

  assign miso = pin_sel[PIN_CONNECT_BIT] ? 1'b0 :
    gpio_sync[pin_sel[4:0]];

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      enable <= ENABLE_OFF;
      pin_sel <= PIN_SEL_RESET;
      bit_rate <= BIT_RATE_RESET;
      rx_max <= '0;
      tx_max <= '0;
      rx_list <= '0;
      tx_list <= '0;
      fmt <= '0;
      fill_char <= '0;
      int_mask <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        OFF_ENABLE: enable <= reg_wdata[3:0];
        OFF_IN_PIN_SEL: pin_sel <= reg_wdata;
        OFF_BIT_RATE: bit_rate <= reg_wdata;
        OFF_RX_MAX: rx_max <= reg_wdata[CNT_W-1:0];
        OFF_TX_MAX: tx_max <= reg_wdata[CNT_W-1:0];
        OFF_RX_LIST: rx_list <= reg_wdata[1:0];
        OFF_TX_LIST: tx_list <= reg_wdata[1:0];
        OFF_FORMAT: fmt <= reg_wdata[2:0];
        OFF_FILL_CHAR: fill_char <= reg_wdata[7:0];
        OFF_INT_MASK: int_mask <= reg_wdata[EV_W-1:0];
        default: ;
      endcase
    end
  end

  // Pointers, advanced after a transaction in array-list mode
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_ptr <= '0;
      tx_ptr <= '0;
    end else if (state == ST_DONE) begin
      if (rx_list == LIST_ARRAY) begin
        rx_ptr <= rx_ptr + 32'(rx_max);
      end
      if (tx_list == LIST_ARRAY) begin
        tx_ptr <= tx_ptr + 32'(tx_max);
      end
    end else if (reg_wr && reg_addr == OFF_RX_PTR) begin
      rx_ptr <= reg_wdata;
    end else if (reg_wr && reg_addr == OFF_TX_PTR) begin
      tx_ptr <= reg_wdata;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_INT_STATUS: reg_rdata <= 32'(int_status);
        OFF_INT_MASK: reg_rdata <= 32'(int_mask);
        OFF_ENABLE: reg_rdata <= 32'(enable);
        OFF_IN_PIN_SEL: reg_rdata <= pin_sel;
        OFF_BIT_RATE: reg_rdata <= bit_rate;
        OFF_RX_PTR: reg_rdata <= rx_ptr;
        OFF_RX_MAX: reg_rdata <= 32'(rx_max);
        OFF_RX_AMOUNT: reg_rdata <= 32'(rx_amount);
        OFF_RX_LIST: reg_rdata <= 32'(rx_list);
        OFF_TX_PTR: reg_rdata <= tx_ptr;
        OFF_TX_MAX: reg_rdata <= 32'(tx_max);
        OFF_TX_AMOUNT: reg_rdata <= 32'(tx_amount);
        OFF_TX_LIST: reg_rdata <= 32'(tx_list);
        OFF_FORMAT: reg_rdata <= 32'(fmt);
        OFF_FILL_CHAR: reg_rdata <= 32'(fill_char);
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ****************************************
  // Events and interrupt
  // ****************************************
  always_comb begin
    ev_set = '0;
    ev_set[EV_STARTED] = (state == ST_WAIT) && (lat_cnt == 8'h00);
    ev_set[EV_ENDRX] = (state == ST_DONE);
    ev_set[EV_ENDTX] = (state == ST_DONE);
    ev_set[EV_END] = (state == ST_DONE);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      int_status <= '0;
    end else if (reg_rd && reg_addr == OFF_INT_STATUS) begin
      int_status <= ev_set;
    end else begin
      int_status <= int_status | ev_set;
    end
  end

  assign irq = |(int_status & int_mask);

  // ****************************************
  // Rate divider
  // ****************************************
  always_comb begin
    case (bit_rate)
      rate_125k_code: half_cnt = HALF_125K;
      RATE_250K_CODE: half_cnt = HALF_250K;
      RATE_500K_CODE: half_cnt = HALF_500K;
      RATE_1M_CODE: half_cnt = HALF_1M;
      RATE_2M_CODE: half_cnt = HALF_2M;
      RATE_4M_CODE: half_cnt = HALF_4M;
      rate_8m_code: half_cnt = HALF_8M;
      default: half_cnt = HALF_250K;
    endcase
  end

  assign tick = (state == ST_SHIFT) && (div_cnt == 9'h000);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= '0;
    end else if (state != ST_SHIFT || tick) begin
      div_cnt <= half_cnt;
    end else begin
      div_cnt <= div_cnt - 9'h001;
    end
  end

  // ****************************************
  // Transfer sequencing
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (start) next_state = ST_WAIT;
      ST_WAIT: if (lat_cnt == 8'h00) begin
        next_state = (total == '0) ? ST_DONE : ST_FETCH;
      end
      ST_FETCH: if (load) next_state = ST_SHIFT;
      ST_SHIFT: if (tick && edge_cnt == LAST_EDGE) next_state = ST_STORE;
      ST_STORE: if (rx_cnt >= rx_max || mem_wr_ack) begin
        next_state = (byte_cnt + 13'h0001 >= total) ? ST_DONE : ST_FETCH;
      end
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
    if (!running) next_state = ST_IDLE;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Start latency
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lat_cnt <= '0;
    end else if (state == ST_IDLE) begin
      lat_cnt <= 8'(START_LAT_CYC - 1);
    end else if (state == ST_WAIT && lat_cnt != 8'h00) begin
      lat_cnt <= lat_cnt - 8'h01;
    end
  end

  // Byte source: RAM while within limit, else fill character
  assign mem_rd_req = (state == ST_FETCH) && (tx_cnt < tx_max);
  assign load = (state == ST_FETCH) && (tx_cnt >= tx_max || mem_rd_ack);
  assign load_byte = (tx_cnt < tx_max) ? mem_rd_data : fill_char;
  assign mem_wr_req = (state == ST_STORE) && (rx_cnt < rx_max);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mem_rd_addr <= '0;
      mem_wr_addr <= '0;
    end else begin
      mem_rd_addr <= tx_ptr + 32'(tx_cnt);
      mem_wr_addr <= rx_ptr + 32'(rx_cnt);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mem_wr_data <= '0;
    end else if (state == ST_SHIFT && next_state == ST_STORE) begin
      mem_wr_data <= !cpha ? rx_sh :
        (lsb_first ? {miso, rx_sh[7:1]} : {rx_sh[6:0], miso});
    end
  end

  // Byte counters
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      byte_cnt <= '0;
      tx_cnt <= '0;
      rx_cnt <= '0;
    end else if (state == ST_IDLE) begin
      byte_cnt <= '0;
      tx_cnt <= '0;
      rx_cnt <= '0;
    end else begin
      if (load && tx_cnt < tx_max) begin
        tx_cnt <= tx_cnt + 13'h0001;
      end
      if (state == ST_STORE && mem_wr_req && mem_wr_ack) begin
        rx_cnt <= rx_cnt + 13'h0001;
      end
      if (state == ST_STORE && next_state != ST_STORE) begin
        byte_cnt <= byte_cnt + 13'h0001;
      end
    end
  end

  // Amounts latched at the end of a transaction
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_amount <= '0;
      tx_amount <= '0;
    end else if (state == ST_DONE) begin
      rx_amount <= rx_cnt;
      tx_amount <= tx_cnt;
    end
  end

  // ****************************************
  // Shift engine
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sck_out <= 1'b0;
      mosi_out <= 1'b0;
      tx_sh <= '0;
      rx_sh <= '0;
      edge_cnt <= '0;
    end else if (load) begin
      sck_out <= cpol;
      edge_cnt <= '0;
      if (!cpha) begin
        mosi_out <= lsb_first ? load_byte[0] : load_byte[7];
        tx_sh <= lsb_first ? load_byte >> 1 : load_byte << 1;
      end else begin
        tx_sh <= load_byte;
      end
    end else if (tick) begin
      sck_out <= ~sck_out;
      edge_cnt <= edge_cnt + 4'h1;
      if (edge_cnt[0] == cpha) begin
        rx_sh <= lsb_first ? {miso, rx_sh[7:1]} : {rx_sh[6:0], miso};
      end else if (edge_cnt != LAST_EDGE) begin
        mosi_out <= lsb_first ? tx_sh[0] : tx_sh[7];
        tx_sh <= lsb_first ? tx_sh >> 1 : tx_sh << 1;
      end
    end else if (state == ST_IDLE) begin
      sck_out <= cpol;
    end
  end
endmodule : spm_master
`default_nettype wire

// >>> verilog/spm_pkg.sv
// What this block does
// - Bit rate is chosen by a one-hot rate code, 125 kbps up to 8 Mbps.
// - Serial input comes from the pin numbered 0..31; connect bit high disconnects.
// - Receive channel writes at most the maximum receive byte count to RAM.
// - Transmit channel reads at most the maximum transmit byte count from RAM.
// - Each channel reports bytes moved in the last transaction, read-only.
// - Bytes beyond the transmit buffer shift out the over-read fill character.
// - Serial transfer starts about one microsecond after the start command.
// - Master runs only while the enable field holds 7.
// - End event is raised once both buffer limits have been reached.
package spm_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] OFF_TASK_START = 12'h010;
  localparam logic [11:0] OFF_INT_STATUS = 12'h100;
  localparam logic [11:0] OFF_INT_MASK = 12'h300;
  localparam logic [11:0] OFF_ENABLE = 12'h500;
  localparam logic [11:0] OFF_IN_PIN_SEL = 12'h510;
  localparam logic [11:0] OFF_BIT_RATE = 12'h524;
  localparam logic [11:0] OFF_RX_PTR = 12'h534;
  localparam logic [11:0] OFF_RX_MAX = 12'h538;
  localparam logic [11:0] OFF_RX_AMOUNT = 12'h53C;
  localparam logic [11:0] OFF_RX_LIST = 12'h540;
  localparam logic [11:0] OFF_TX_PTR = 12'h544;
  localparam logic [11:0] OFF_TX_MAX = 12'h548;
  localparam logic [11:0] OFF_TX_AMOUNT = 12'h54C;
  localparam logic [11:0] OFF_TX_LIST = 12'h550;
  localparam logic [11:0] OFF_FORMAT = 12'h554;
  localparam logic [11:0] OFF_FILL_CHAR = 12'h5C0;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int CNT_W = 13;
  localparam logic [3:0] ENABLE_ON = 4'h7;
  localparam logic [3:0] ENABLE_OFF = 4'h0;
  localparam int PIN_CONNECT_BIT = 31;
  localparam logic [31:0] PIN_SEL_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] BIT_RATE_RESET = 32'h04000000;
  localparam int FMT_ORDER_BIT = 0;
  localparam int FMT_CPHA_BIT = 1;
  localparam int FMT_CPOL_BIT = 2;
  localparam logic [1:0] LIST_ARRAY = 2'h1;
  localparam int EV_STARTED = 0;
  localparam int EV_ENDRX = 1;
  localparam int EV_END = 2;
  localparam int EV_ENDTX = 3;
  localparam int EV_W = 4;
  // ****************************************
  // Rate codes
  // ****************************************
  localparam logic [31:0] rate_125k_code = 32'h02000000;
  localparam logic [31:0] RATE_250K_CODE = 32'h04000000;
  localparam logic [31:0] RATE_500K_CODE = 32'h08000000;
  localparam logic [31:0] RATE_1M_CODE = 32'h10000000;
  localparam logic [31:0] RATE_2M_CODE = 32'h20000000;
  localparam logic [31:0] RATE_4M_CODE = 32'h40000000;
  localparam logic [31:0] rate_8m_code = 32'h80000000;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ = 125000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int START_LAT_NS = 1000;
  localparam int START_LAT_CYC = (START_LAT_NS + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam logic [8:0] HALF_125K = 9'(CLK_KHZ / (2 * 125) - 1);
  localparam logic [8:0] HALF_250K = 9'(CLK_KHZ / (2 * 250) - 1);
  localparam logic [8:0] HALF_500K = 9'(CLK_KHZ / (2 * 500) - 1);
  localparam logic [8:0] HALF_1M = 9'(CLK_KHZ / (2 * 1000) - 1);
  localparam logic [8:0] HALF_2M = 9'(CLK_KHZ / (2 * 2000) - 1);
  localparam logic [8:0] HALF_4M = 9'(CLK_KHZ / (2 * 4000) - 1);
  localparam logic [8:0] HALF_8M = 9'(CLK_KHZ / (2 * 8000) - 1);
  localparam logic [3:0] LAST_EDGE = 4'hF;
  // ****************************************
  // Transfer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_FETCH, ST_SHIFT, ST_STORE, ST_DONE
  } spm_state_t;
endpackage : spm_pkg

// >>> verilog/spm_sync.sv
`timescale 1ns/1ns
`default_nettype none
module spm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Change taken once stages two and three agree
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= (s3 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
    end
  end
endmodule : spm_sync
`default_nettype wire
